// File: rtl/dac_link_pkg.sv
// Shared constants for the serial converter link and its two ends
package dac_link_pkg;
  localparam int          FRAME_BITS      = 24;        // Bits per write frame
  localparam int          CNT_W           = 5;         // Width of the falling-edge counter
  localparam logic [4:0]  LAST_EDGE       = 5'h17;     // Index of the 24th falling edge
  localparam int          CODE_W          = 18;        // Full data code width
  localparam int          CORE_W          = 16;        // Core converter code width
  localparam int          INTERP_W        = 2;         // Interpolator code width
  localparam int          CODE_MSB        = 19;        // Frame position of code bit 17
  localparam int          CORE_MSB        = 19;        // Frame position of core code msb
  localparam int          CORE_LSB        = 4;         // Frame position of core code lsb
  localparam int          INTERP_MSB      = 3;         // Frame position of interpolator msb
  localparam int          INTERP_LSB      = 2;         // Frame position of interpolator lsb
  localparam logic [17:0] CODE_ZERO       = 18'h00000; // Zero scale power-up code
  localparam logic [17:0] CODE_MID        = 18'h20000; // Midscale power-up code
  localparam logic [1:0]  INTERP_PHASES   = 2'h3;      // Last phase of a four-step duty period
  localparam int          CLK_MHZ         = 125;       // System clock rate
  localparam int          SYNC_HIGH_NS    = 33;        // Least frame sync high time
  localparam int          SCLK_MAX_MHZ    = 30;        // Fastest serial clock
  // Least high time rounded up to whole cycles
  localparam int          SYNC_HIGH_CYC   = (SYNC_HIGH_NS * CLK_MHZ + 999) / 1000;
  // Least serial half period rounded up plus one cycle, for the host divider
  localparam int          SCLK_HALF_CYC   = (1000 * CLK_MHZ / SCLK_MAX_MHZ / 2 + 999) / 1000 + 1;
  localparam int          INTERP_DIV      = 16;        // Default system cycles per interpolator step
endpackage

// File: rtl/dac_link_if.sv
// Three-wire write-only link between host and converter
`timescale 1ns/1ps
interface dac_link_if;
  logic sync_n; // Frame sync, active low, driven by host
  logic sclk;   // Serial clock, driven by host
  logic sdata;  // Serial data, driven by host

  modport host (output sync_n, output sclk, output sdata);
  modport dev  (input  sync_n, input  sclk, input  sdata);
endinterface

// File: rtl/dac_link_dev.sv
// Converter end: serial receiver, converter register and interpolator
`timescale 1ns/1ps
// Behaviour
// - frame armed after sync falling edge
// - shift data on sclk falls
// - 24th fall loads converter register
// - host holds sync high 33 ns
// - host may park sync low
// - code is unsigned straight binary
// - bits 19..4 core, 3..2 interpolator
// - duty at C+1 is 0/25/50/75%
// - free-running internal interpolator clock
// - host sclk at most 30 MHz
// - early sync rise aborts frame
// - frame: 2 ignored, 2 reserved, 18, 2
// - power-up zero or midscale until write
// - host sends msb first
module dac_link_dev #(
  parameter bit MIDSCALE   = 1'b0,                   // Power-up variant: 0 zero scale, 1 midscale
  parameter int INTERP_DIV = dac_link_pkg::INTERP_DIV // System cycles per interpolator step
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  dac_link_if.dev          link,
  output logic [17:0]      code,        // Loaded 18-bit code
  output logic [15:0]      core_code,   // Code presented to the core converter
  output logic             update       // One-cycle pulse when a frame loads
);
  // Positions of the three pins inside the synchroniser bank
  localparam int PIN_SYNC  = 0;          // Frame sync, active low
  localparam int PIN_SCLK  = 1;          // Serial clock
  localparam int PIN_DATA  = 2;          // Serial data
  localparam int PIN_COUNT = 3;          // Pins brought into the mclk domain

  // Synchroniser bank, one bit per pin
  logic [PIN_COUNT-1:0] pin_raw;         // Pins as they arrive, asynchronous to mclk
  logic [PIN_COUNT-1:0] pin_meta_r;      // First stage, may go metastable
  logic [PIN_COUNT-1:0] pin_sync_r;      // Second stage, the only stage logic may read
  logic [PIN_COUNT-1:0] pin_prev_r;      // Second stage one cycle older, for edge finding

  // Levels and edges seen through the synchronisers
  logic                 sync_low;        // Frame sync is asserted
  logic                 sync_fall;       // Frame sync went low: a frame starts
  logic                 sync_rise;       // Frame sync went high: a frame ends or aborts
  logic                 sclk_fall;       // Serial clock fell while sync is low
  logic                 data_bit;        // Serial data bit, aligned with the clock edges

  // Receive side
  logic                 armed_r;         // Frame in progress, clock edges are counted
  logic [4:0]           cnt_r;           // Falling edges taken in this frame
  logic [23:0]          shift_r;         // Input shift register, first bit ends at the top
  logic [23:0]          shift_nxt;       // Shift register with the current bit appended
  logic                 last_edge;       // The counter stands on the last edge of a frame
  logic                 load;            // A complete frame lands this cycle

  // Converter register and the split of its code
  logic [17:0]          code_r;          // Converter register
  logic                 update_r;        // Load pulse
  logic [15:0]          code_core;       // Upper part of the code, the core value C
  logic [1:0]           code_interp;     // Lower part of the code, the duty fraction
  logic                 core_full;       // C is already full scale, C+1 would wrap

  // Interpolator
  logic [15:0]          div_r;           // Interpolator step timer
  logic                 div_wrap;        // Timer reaches the end of a step
  logic [1:0]           phase_r;         // Phase within a four-step duty period
  logic                 bump;            // Core sees C+1 in this phase
  logic [15:0]          core_r;          // Core code output register

  // Gather the pins in PIN_ order so the bank moves through one set of flops
  assign pin_raw = {link.sdata, link.sclk, link.sync_n};

  // Three flops per pin. No reset: the bank flushes itself while reset is held,
  // and a forced value could fake an edge on the first cycle after release.
  always_ff @(posedge mclk) begin
    pin_meta_r <= pin_raw;
    pin_sync_r <= pin_meta_r;
    pin_prev_r <= pin_sync_r;
  end

  // Edge finders read only the second stage and its delayed copy
  assign sync_low  = ~pin_sync_r[PIN_SYNC];
  assign sync_fall = pin_prev_r[PIN_SYNC] & sync_low;
  assign sync_rise = ~pin_prev_r[PIN_SYNC] & ~sync_low;
  // Clock falls only count as data edges while the frame sync is low
  assign sclk_fall = pin_prev_r[PIN_SCLK] & ~pin_sync_r[PIN_SCLK] & sync_low;
  // Data passes the same two stages as the clock, so it lines up with the edge
  assign data_bit  = pin_sync_r[PIN_DATA];

  // Msb arrives first and walks up to bit 23
  assign shift_nxt = {shift_r[dac_link_pkg::FRAME_BITS-2:0], data_bit};
  // The counter sits on the last edge of the frame
  assign last_edge = (cnt_r == dac_link_pkg::LAST_EDGE);
  // A sync edge in the same cycle wins over the last clock edge: the frame is dropped
  assign load      = armed_r & sclk_fall & last_edge & ~sync_rise & ~sync_fall;

  // Frame state: arm only on a real falling sync, never on a low level left from reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      armed_r <= 1'b0;
    end else if (sync_fall) begin
      // New frame, whatever the previous one left behind
      armed_r <= 1'b1;
    end else if (sync_rise) begin
      // Early rise abandons the frame
      armed_r <= 1'b0;
    end else if (armed_r && sclk_fall && last_edge) begin
      // Further clock edges are ignored until sync falls again
      armed_r <= 1'b0;
    end
  end

  // Edge counter: restarts at every sync fall so each frame counts from zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (sync_fall) begin
      cnt_r <= '0;
    end else if (sync_rise) begin
      cnt_r <= '0;
    end else if (armed_r && sclk_fall) begin
      if (last_edge) begin
        // Back to zero so a stray count never carries into the next frame
        cnt_r <= '0;
      end else begin
        // One more bit taken
        cnt_r <= cnt_r + 5'h01;
      end
    end
  end

  // Input shift register: cleared at each frame start and at each abort
  always_ff @(posedge mclk) begin
    if (rst) begin
      shift_r <= '0;
    end else if (sync_fall) begin
      shift_r <= '0;
    end else if (sync_rise) begin
      // Half a frame must never leak into a later one
      shift_r <= '0;
    end else if (armed_r && sclk_fall) begin
      shift_r <= shift_nxt;
    end
  end

  // Converter register: power-up value held until a full frame lands
  always_ff @(posedge mclk) begin
    if (rst) begin
      code_r <= MIDSCALE ? dac_link_pkg::CODE_MID : dac_link_pkg::CODE_ZERO;
    end else if (load) begin
      // Ignored and reserved bits dropped; data is unsigned straight binary
      code_r <= shift_nxt[dac_link_pkg::CODE_MSB -: dac_link_pkg::CODE_W];
    end
  end

  // Load pulse, exactly one cycle per landed frame
  always_ff @(posedge mclk) begin
    if (rst) begin
      update_r <= 1'b0;
    end else begin
      update_r <= load;
    end
  end

  // Interpolator step timer; runs from mclk alone, never from the serial clock
  assign div_wrap = (div_r == 16'(INTERP_DIV - 1));

  always_ff @(posedge mclk) begin
    if (rst) begin
      div_r <= '0;
    end else if (div_wrap) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  // Phase walks through four equal steps and wraps
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase_r <= '0;
    end else if (div_wrap) begin
      if (phase_r == dac_link_pkg::INTERP_PHASES) begin
        phase_r <= '0;
      end else begin
        phase_r <= phase_r + 2'h1;
      end
    end
  end

  // Upper 16 bits feed the core, lower 2 bits set the duty fraction
  assign code_core   = code_r[dac_link_pkg::CODE_W-1 -: dac_link_pkg::CORE_W];
  assign code_interp = code_r[dac_link_pkg::INTERP_W-1:0];
  // Full scale core has no C+1; such a code simply stays at C
  assign core_full   = (code_core == '1);
  // C+1 in the first code_interp of four phases: 0, 25, 50 or 75 percent
  assign bump        = (phase_r < code_interp) & ~core_full;

  // Core input register; it follows a new code one cycle after the load
  always_ff @(posedge mclk) begin
    if (rst) begin
      core_r <= '0;
    end else if (bump) begin
      core_r <= code_core + 16'h0001;
    end else begin
      core_r <= code_core;
    end
  end

  // Outputs come straight from their registers
  assign code      = code_r;
  assign core_code = core_r;
  assign update    = update_r;
endmodule

// File: rtl/dac_link_host.sv
// Host end: sends one 24-bit frame per request, msb first
`timescale 1ns/1ps
module dac_link_host #(
  parameter int HALF_CYC = dac_link_pkg::SCLK_HALF_CYC, // System cycles per sclk half period
  parameter int GAP_CYC  = dac_link_pkg::SYNC_HIGH_CYC  // Least sync high cycles between frames
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  dac_link_if.host         link,
  input  wire logic        req,       // Send request, level sampled when ready
  input  wire logic [17:0] req_code,  // Code to send
  input  wire logic        park_low,  // Idle sync low between frames
  output logic             ready      // High when a request can be taken
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_GAP  = 2'b01,
    ST_SEND = 2'b10
  } st_t;

  st_t         st_r;
  logic [23:0] frame_r;     // Outgoing bits, msb at top
  logic [4:0]  bit_r;       // Bits sent
  logic [7:0]  tick_r;      // Timing counter
  logic        sync_n_r;
  logic        sclk_r;
  logic        pend_r;      // Request held through the gap

  assign ready = (st_r == ST_IDLE) && !pend_r;

  // Frame sequencer; sclk held under 30 MHz by the half period divider
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r     <= ST_IDLE;
      frame_r  <= '0;
      bit_r    <= '0;
      tick_r   <= '0;
      sync_n_r <= 1'b1;
      sclk_r   <= 1'b1;
      pend_r   <= 1'b0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          sync_n_r <= park_low ? 1'b0 : 1'b1;
          if (req && ready) begin
            // Ignored, reserved zeros, code, ignored; msb first
            frame_r  <= {4'h0, req_code, 2'h0};
            pend_r   <= 1'b1;
            sync_n_r <= 1'b1;
            tick_r   <= '0;
            st_r     <= ST_GAP;
          end
        end
        ST_GAP: begin
          // Sync high long enough, then falls to start the frame
          if (tick_r == 8'(GAP_CYC)) begin
            sync_n_r <= 1'b0;
            tick_r   <= '0;
            bit_r    <= '0;
            st_r     <= ST_SEND;
          end else begin
            tick_r <= tick_r + 8'h01;
          end
        end
        ST_SEND: begin
          if (tick_r == 8'(HALF_CYC - 1)) begin
            tick_r <= '0;
            sclk_r <= ~sclk_r;
            if (!sclk_r) begin
              if (bit_r == dac_link_pkg::LAST_EDGE) begin
                pend_r <= 1'b0;
                st_r   <= ST_IDLE;
              end else begin
                frame_r <= {frame_r[22:0], 1'b0};
                bit_r   <= bit_r + 5'h01;
              end
            end
          end else begin
            tick_r <= tick_r + 8'h01;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  assign link.sync_n = sync_n_r;
  assign link.sclk   = sclk_r;
  assign link.sdata  = frame_r[23];
endmodule

// File: sim/dac_link_monitor.sv
// Checker on the host-to-converter link and the converter outputs
`timescale 1ns/1ps
module dac_link_monitor (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        sync_n,
  input wire logic        sclk,
  input wire logic        sdata,
  input wire logic [17:0] code,
  input wire logic [15:0] core_code,
  input wire logic        update
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic [4:0] falls_r; // Raw sclk falls since the last sync fall, saturates at 24
  logic       sclk_r;  // Previous sclk sample
  logic       sync_r;  // Previous sync sample
  // Edge history
  always_ff @(posedge mclk) begin
    sclk_r <= sclk;
    sync_r <= sync_n;
  end
  // Saturating so that stray edges after a load never look like a new frame
  always_ff @(posedge mclk) begin
    if (rst || (sync_r && !sync_n)) begin
      falls_r <= 5'h00;
    end else if (sclk_r && !sclk && !sync_n && falls_r != 5'h18) begin
      falls_r <= falls_r + 5'h01;
    end
  end
  sequence s_last_fall;
    $fell(sclk) && !sync_n && falls_r == 5'h17;
  endsequence
  a_load_latency: assert property (s_last_fall |-> ##[2:6] update)
    else $error("no load after last fall");
  a_load_counted: assert property (update |-> falls_r == 5'h18)
    else $error("load without 24 falls");
  a_code_only_load: assert property (!$stable(code) |-> update || $past(update))
    else $error("code changed without a load");
  a_sync_gap: assert property ($fell(sync_n) |-> $past(sync_n, 3) && $past(sync_n, 5))
    else $error("sync high too short");
  a_sclk_idle: assert property (sync_n |-> sclk)
    else $error("sclk low outside a frame");
  a_sclk_low_half: assert property ($fell(sclk) |-> (!sclk)[*4] ##1 sclk)
    else $error("sclk low phase wrong");
  a_sclk_high_half: assert property ($rose(sclk) |-> sclk[*4])
    else $error("sclk high phase short");
  a_data_hold: assert property ($fell(sclk) |-> $stable(sdata))
    else $error("data moved at sclk fall");
  a_core_pair: assert property (!update && !$past(update) |->
    core_code == code[17:2] || core_code == code[17:2] + 16'h0001)
    else $error("core code outside C and C+1");
  a_no_interp: assert property (!update && !$past(update) && code[1:0] == 2'h0 |-> core_code == code[17:2])
    else $error("core code switched with zero fraction");
endmodule

// File: sim/tb_serial_dac_input_interpolator.sv
// Self-checking bench joining host and converter ends, plus a bench-driven link
`timescale 1ns/1ps
module tb_serial_dac_input_interpolator;
  logic        mclk, rst, req, park_low, ready, update, update2;
  logic [17:0] req_code, code, code2;
  logic [15:0] core_code;
  int          fail_count, comparisons, upd2_n, hi_n;
  logic [17:0] codes [4] = '{18'h3ffff, 18'h00000, 18'h2aaaa, 18'h15555};
  dac_link_if link ();
  dac_link_if link2 (); // Driven by the bench to break host rules on purpose
  dac_link_host dac_link_host_i (.mclk, .rst, .link(link.host), .req, .req_code, .park_low, .ready);
  dac_link_dev #(.INTERP_DIV(4)) dac_link_dev_i (.mclk, .rst, .link(link.dev), .code, .core_code, .update);
  dac_link_dev #(.INTERP_DIV(4)) dac_link_dev_b_i (.mclk, .rst, .link(link2.dev), .code(code2),
    .core_code(), .update(update2));
  dac_link_monitor dac_link_monitor_i (.mclk, .rst, .sync_n(link.sync_n), .sclk(link.sclk),
    .sdata(link.sdata), .code, .core_code, .update);
  // System clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Loads seen on the second converter
  always @(negedge mclk) if (update2 === 1'b1) upd2_n++;
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Request raised once the host is idle, so the next edge takes it; then wait for the load
  task automatic send(input logic [17:0] c, input logic pl);
    @(negedge mclk);
    while (ready !== 1'b1) @(negedge mclk);
    req = 1'b1;
    req_code = c;
    park_low = pl;
    @(negedge mclk);
    req = 1'b0;
    for (int k = 0; k < 400 && update !== 1'b1; k++) @(negedge mclk);
    check(18'(update), 18'h00001);
    check(code, c);
  endtask
  // Four whole interpolator periods, so the C+1 count is exact at any phase
  task automatic duty(input logic [17:0] c);
    send(c, 1'b0);
    repeat (4) @(negedge mclk);
    hi_n = 0;
    repeat (64) begin
      @(negedge mclk);
      if (core_code === c[17:2] + 16'h0001) hi_n++;
    end
    check(18'(hi_n), 18'(16 * c[1:0]));
  endtask
  // Bit-banged frame at an 80 ns link period; data inverted once released
  task automatic bang(input logic [23:0] f, input int n, input logic rise);
    if (rise) begin
      link2.sync_n = 1'b1;
      repeat (5) @(negedge mclk);
      link2.sync_n = 1'b0;
    end
    for (int i = 0; i < n; i++) begin
      link2.sdata = f[23 - i];
      link2.sclk = 1'b1;
      repeat (5) @(negedge mclk);
      link2.sclk = 1'b0;
      repeat (5) @(negedge mclk);
    end
    link2.sclk = 1'b1;
    link2.sdata = ~link2.sdata;
    repeat (10) @(negedge mclk);
  endtask
  initial begin
    rst = 1'b1;
    {req, park_low, req_code} = '0;
    {link2.sync_n, link2.sclk, link2.sdata} = 3'b110;
    {fail_count, comparisons, upd2_n} = '0;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    check(code, 18'h00000);
    foreach (codes[i]) send(codes[i], 1'(i));
    for (int k = 0; k < 4; k++) duty(18'h00ffc + 18'(k));
    bang({4'hc, 18'h2aaaa, 2'h3}, 23, 1'b1);
    link2.sync_n = 1'b1;
    bang({4'hc, 18'h2aaaa, 2'h3}, 1, 1'b0);
    check(code2, 18'h00000);
    bang({4'hc, 18'h1e0f1, 2'h3}, 24, 1'b1);
    check(code2, 18'h1e0f1);
    bang({4'hc, 18'h0abcd, 2'h3}, 24, 1'b0);
    check(code2, 18'h1e0f1);
    check(18'(upd2_n), 18'h00001);
    stop_test();
  end
  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
endmodule
